// ### rtl/irqf_pkg.sv
// constants for the interrupt request flag block
package irqf_pkg;
    localparam logic [11:0] OFF_FLAGS_A = 12'h018;
    localparam logic [11:0] OFF_FLAGS_B = 12'h01c;
    localparam logic [11:0] OFF_ENABLE_A = 12'h020;
    localparam logic [11:0] OFF_ENABLE_B = 12'h024;
    localparam logic [11:0] OFF_CMD = 12'h040;
    localparam int IDX_FLAGS_A = 6;
    localparam int IDX_FLAGS_B = 7;
    localparam int IDX_ENABLE_A = 8;
    localparam int IDX_ENABLE_B = 9;
    localparam int BIT_SET = 7;
    localparam int BIT_HIGH = 6;
    localparam int BIT_LOW = 5;
    localparam int BIT_DONE = 4;
    localparam int BIT_TX = 3;
    localparam int BIT_RX = 2;
    localparam int BIT_ERR = 1;
    localparam int BIT_SOF = 0;
    localparam int BIT_GLOBAL = 6;
    localparam int BIT_CARD = 5;
    localparam int BIT_INVERT = 7;
    localparam int BIT_PIN_EN = 6;
    localparam int BIT_PUSH_PULL = 7;
    localparam int NUM_TIMERS = 5;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [6:0] MASK_A = 7'h7f;
    localparam logic [6:0] MASK_B = 7'h3f;
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [3:0] CMD_LAST_KNOWN = 4'h9;
endpackage

// ### rtl/irqf_top.sv
// interrupt request flag registers with apb slave and request pin
`timescale 1ns/10ps
module irqf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fifo_high_level_status,
    input wire logic fifo_low_level_status,
    input wire logic command_ended,
    input wire logic transmit_done,
    input wire logic receive_end,
    input wire logic fifo_write_error,
    input wire logic fifo_overflow_error,
    input wire logic protocol_error,
    input wire logic no_data_error,
    input wire logic integrity_error,
    input wire logic frame_start,
    input wire logic card_detected,
    input wire logic [4:0] timer_underflow,
    output logic [3:0] command_code,
    output logic irq_pin_out,
    output logic irq_pin_oe,
    output logic irq
);
    logic [6:0] flags_a_reg;
    logic [6:0] flags_a_next;
    logic [5:0] flags_b_reg;
    logic [5:0] flags_b_next;
    logic [7:0] enable_a_reg;
    logic [7:0] enable_b_reg;
    logic [3:0] cmd_reg;
    logic [3:0] cmd_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    wire access = psel && penable;
    wire wr = access && pwrite && pstrb[0];
    wire rd = access && !pwrite;
    wire sel_a = paddr == irqf_pkg::OFF_FLAGS_A;
    wire sel_b = paddr == irqf_pkg::OFF_FLAGS_B;
    wire sel_ea = paddr == irqf_pkg::OFF_ENABLE_A;
    wire sel_eb = paddr == irqf_pkg::OFF_ENABLE_B;
    wire sel_cmd = paddr == irqf_pkg::OFF_CMD;
    wire mapped = sel_a || sel_b || sel_ea || sel_eb || sel_cmd;
    wire wr_a = wr && sel_a;
    wire wr_b = wr && sel_b;
    wire wr_cmd = wr && sel_cmd;
    wire set_mode = pwdata[irqf_pkg::BIT_SET];
    wire [6:0] hit_a = pwdata[6:0] & irqf_pkg::MASK_A & {7{wr_a}};
    wire [5:0] hit_b = pwdata[5:0] & irqf_pkg::MASK_B[5:0] & {6{wr_b}};

    // command field: unknown codes fall back to idle; host idle writes raise nothing
    wire cmd_unknown = wr_cmd && (pwdata[3:0] > irqf_pkg::CMD_LAST_KNOWN);
    wire cmd_self_end = !wr_cmd && command_ended && (cmd_reg != irqf_pkg::CMD_IDLE);
    wire done_event = cmd_unknown || cmd_self_end;
    assign cmd_next = wr_cmd ? (cmd_unknown ? irqf_pkg::CMD_IDLE : pwdata[3:0]) :
        (cmd_self_end ? irqf_pkg::CMD_IDLE : cmd_reg);

    wire any_error = fifo_write_error || fifo_overflow_error || protocol_error ||
        no_data_error || integrity_error;
    // hardware events; the receive flag is no proof of good data
    wire [6:0] evt_a = {fifo_high_level_status, fifo_low_level_status, done_event,
        transmit_done, receive_end, any_error, frame_start};
    wire [5:0] evt_b = {card_detected, timer_underflow};

    // events win over host clears
    assign flags_a_next = (set_mode ? (flags_a_reg | hit_a) : (flags_a_reg & ~hit_a)) | evt_a;
    assign flags_b_next = (set_mode ? (flags_b_reg | hit_b) : (flags_b_reg & ~hit_b)) | evt_b;

    wire global_req = |(flags_a_reg & enable_a_reg[6:0]) |
        |(flags_b_reg & enable_b_reg[5:0]);
    wire pin_active = global_req && enable_b_reg[irqf_pkg::BIT_PIN_EN];
    wire pin_level = pin_active ^ enable_a_reg[irqf_pkg::BIT_INVERT];
    wire push_pull = enable_b_reg[irqf_pkg::BIT_PUSH_PULL];

    assign prdata_next = !rd ? prdata_reg :
        sel_a ? {25'h000_0000, flags_a_reg} :
        sel_b ? {25'h000_0000, global_req, flags_b_reg} :
        sel_ea ? {24'h00_0000, enable_a_reg} :
        sel_eb ? {24'h00_0000, enable_b_reg} :
        sel_cmd ? {28'h000_0000, cmd_reg} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_a_reg <= irqf_pkg::FLAGS_RESET[6:0];
            flags_b_reg <= irqf_pkg::FLAGS_RESET[5:0];
            cmd_reg <= irqf_pkg::CMD_IDLE;
            prdata_reg <= 32'h0000_0000;
        end else begin
            flags_a_reg <= flags_a_next;
            flags_b_reg <= flags_b_next;
            cmd_reg <= cmd_next;
            prdata_reg <= prdata_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_a_reg <= irqf_pkg::ENABLE_RESET;
            enable_b_reg <= irqf_pkg::ENABLE_RESET;
        end else begin
            if (wr && sel_ea) begin
                enable_a_reg <= pwdata[7:0];
            end
            if (wr && sel_eb) begin
                enable_b_reg <= pwdata[7:0];
            end
        end
    end

    // zero-wait apb writes: read data is registered at the access edge, so read pready lags one cycle
    logic rd_done_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_done_reg <= 1'b0;
        end else begin
            rd_done_reg <= rd && !rd_done_reg;
        end
    end
    assign pready = pwrite ? 1'b1 : rd_done_reg;
    assign pslverr = access && pready && !mapped;
    assign prdata = prdata_reg;
    assign command_code = cmd_reg;
    // open drain drives only the low level
    assign irq_pin_out = pin_level;
    assign irq_pin_oe = push_pull || !pin_level;
    assign irq = global_req;

    a_set_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_a && pwdata[BIT7] |=> (flags_a_reg & pwdata_q[6:0]) == pwdata_q[6:0])
        else $error("set write missed flag a");
    localparam int BIT7 = 7;
    logic [31:0] pwdata_q;
    always_ff @(posedge pclk) begin
        pwdata_q <= pwdata;
    end
    a_clear_write_b: assert property (@(posedge pclk) disable iff (!presetn)
        wr_b && !pwdata[BIT7] && !(|evt_b) |=> (flags_b_reg & pwdata_q[5:0]) == 6'h00)
        else $error("clear write left flag b");
    a_keep_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_a && !(|evt_a) |=> (flags_a_reg & ~pwdata_q[6:0]) == ($past(flags_a_reg) & ~pwdata_q[6:0]))
        else $error("unwritten flag changed");
    a_high_latch: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_high_level_status |=> flags_a_reg[6])
        else $error("high level not latched");
    a_low_latch: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_low_level_status |=> flags_a_reg[5])
        else $error("low level not latched");
    a_unknown_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_unknown |=> flags_a_reg[4] && cmd_reg == 4'h0)
        else $error("unknown command not handled");
    a_idle_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd && pwdata[3:0] == 4'h0 && !(wr_a && pwdata[BIT7] && pwdata[4])
        && !$past(flags_a_reg[4]) && !flags_a_reg[4] |=> !flags_a_reg[4])
        else $error("host idle set command done");
    a_timer_latch: assert property (@(posedge pclk) disable iff (!presetn)
        timer_underflow[3] |=> flags_b_reg[3])
        else $error("timer flag not set");
    a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_b_reg[6] |-> irq_pin_out == enable_a_reg[7])
        else $error("pin driven while disabled");
endmodule // irqf_top

// ### dv/tb.sv
// self-checking testbench for the interrupt request flag block
`timescale 1ns/10ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic irq, irq_pin_out, irq_pin_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] command_code;
    logic [16:0] ev;
    int errors, total_checks;
    irqf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fifo_high_level_status(ev[0]),
        .fifo_low_level_status(ev[1]), .command_ended(ev[16]), .transmit_done(ev[2]),
        .receive_end(ev[3]), .fifo_write_error(ev[4]), .fifo_overflow_error(ev[5]),
        .protocol_error(ev[6]), .no_data_error(ev[7]), .integrity_error(ev[8]),
        .frame_start(ev[9]), .card_detected(ev[10]), .timer_underflow(ev[15:11]),
        .command_code(command_code), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
        .irq(irq));
    task automatic stop_test();
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        r = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(r, {24'h00_0000, e});
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev <= 17'h0_0001 << i;
        @(posedge pclk);
        ev <= '0;
    endtask
    // irq, pin level, pin drive enable
    task automatic pin(input logic [2:0] e);
        @(negedge pclk);
        chk(32'({irq, irq_pin_out, irq_pin_oe}), 32'(e));
    endtask
    // expected {flags b, flags a} for event input i
    function automatic logic [15:0] emap(input int i);
        if (i < 2) return 16'h0040 >> i;
        if (i < 4) return 16'h0008 >> (i - 2);
        if (i < 9) return 16'h0002;
        if (i == 9) return 16'h0001;
        if (i == 10) return 16'h2000;
        return 16'h0100 << (i - 11);
    endfunction
    task automatic t_set_clear();
        rc(irqf_pkg::OFF_FLAGS_A, 8'h00);
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'hff);
        rc(irqf_pkg::OFF_FLAGS_A, 8'h7f);
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h05);
        rc(irqf_pkg::OFF_FLAGS_A, 8'h7a);
        apb(1'b1, irqf_pkg::OFF_FLAGS_B, 8'hbf);
        rc(irqf_pkg::OFF_FLAGS_B, 8'h3f);
        apb(1'b1, irqf_pkg::OFF_FLAGS_B, 8'h3f);
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h7f);
        rc(irqf_pkg::OFF_FLAGS_B, 8'h00);
    endtask
    task automatic t_events();
        for (int i = 0; i < 16; i++) begin
            pulse(i);
            rc(irqf_pkg::OFF_FLAGS_A, emap(i)[7:0]);
            rc(irqf_pkg::OFF_FLAGS_B, emap(i)[15:8]);
            apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h7f);
            apb(1'b1, irqf_pkg::OFF_FLAGS_B, 8'h3f);
        end
    endtask
    task automatic t_command();
        apb(1'b1, irqf_pkg::OFF_CMD, 8'h03);
        pulse(16);
        rc(irqf_pkg::OFF_FLAGS_A, 8'h10);
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h10);
        apb(1'b1, irqf_pkg::OFF_CMD, 8'h00);
        pulse(16);
        rc(irqf_pkg::OFF_FLAGS_A, 8'h00);
        apb(1'b1, irqf_pkg::OFF_CMD, 8'h0a);
        rc(irqf_pkg::OFF_CMD, 8'h00);
        rc(irqf_pkg::OFF_FLAGS_A, 8'h10);
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h10);
    endtask
    task automatic t_request();
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h81);
        pin(3'h1);
        apb(1'b1, irqf_pkg::OFF_ENABLE_A, 8'h01);
        pin(3'h5);
        rc(irqf_pkg::OFF_FLAGS_B, 8'h40);
        apb(1'b1, irqf_pkg::OFF_ENABLE_B, 8'h40);
        pin(3'h6);
        apb(1'b1, irqf_pkg::OFF_ENABLE_B, 8'hc0);
        pin(3'h7);
        apb(1'b1, irqf_pkg::OFF_ENABLE_A, 8'h81);
        pin(3'h5);
        rc(irqf_pkg::OFF_ENABLE_B, 8'hc0);
        apb(1'b1, irqf_pkg::OFF_FLAGS_A, 8'h01);
        pin(3'h3);
        rc(12'h0fc, 8'h00);
        chk(32'(slverr), 32'h0000_0001);
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, ev} = '0;
        pin(3'h1);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_set_clear();
        t_events();
        t_command();
        t_request();
        stop_test();
    end
endmodule // tb
